// >>> bench/lps_host_model.sv
// two-wire bus master model that writes the led block's registers
// assumes a pull-up on sda and the device's active-low pull-down enable
`timescale 1ns/1ps

module lps_host_model (
	input  wire logic i_ref_clk,
	input  wire logic i_sda_oe_n,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_line
);
	// ----------------------------------------
	// open-drain line
	// ----------------------------------------
	logic sda_drv = 1'b1;
	// pulled up unless master or device pulls low
	assign o_sda_line = sda_drv & (i_sda_oe_n | i_sda);
	initial o_scl = 1'b1;

	// ----------------------------------------
	// bus steps
	// ----------------------------------------
	// phases of 8 clocks clear the device's input filter with margin
	task automatic wt(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask

	task automatic start;
		sda_drv = 1'b0;
		wt(8);
		o_scl = 1'b0;
		wt(4);
	endtask

	// sda moves mid-low so it never races the scl edge in the sync
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_drv = b[i];
			wt(4);
			o_scl = 1'b1;
			wt(8);
			o_scl = 1'b0;
			wt(4);
		end
		// the device pulls sda about 5 clocks after scl falls, so
		// scl must stay low longer here or the ack looks like a start
		sda_drv = 1'b1;
		wt(8);
		o_scl = 1'b1;
		wt(6);
		ack = ~o_sda_line;
		wt(2);
		o_scl = 1'b0;
		wt(4);
	endtask

	task automatic stop;
		sda_drv = 1'b0;
		wt(4);
		o_scl = 1'b1;
		wt(8);
		sda_drv = 1'b1;
		wt(8);
	endtask
endmodule

// >>> bench/lps_top_test.sv
// self-checking bench for the led pwm block, writes through the bus model
// assumes a 100 MHz clock and the register map of lps_consts.svh
`timescale 1ns/1ps
`include "lps_consts.svh"

module lps_top_test;
	// ----------------------------------------
	// clock, reset, pins
	// ----------------------------------------
	logic        i_ref_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        pin_n = 1'b1;
	logic        scl;
	logic        sda_line;
	logic        o_sda;
	logic        sda_oe_n;
	logic [17:0] outs;
	int          mismatches = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          cnt [18];

	initial forever #5 i_ref_clk = ~i_ref_clk;

	lps_top u_lps_top (
		.i_ref_clk        (i_ref_clk),
		.i_rst            (i_rst),
		.i_scl            (scl),
		.i_sda            (sda_line),
		.o_sda            (o_sda),
		.o_sda_oe_n       (sda_oe_n),
		.i_shutdown_pin_n (pin_n),
		.o_channel_outputs(outs)
	);

	lps_host_model u_lps_host_model (
		.i_ref_clk (i_ref_clk),
		.i_sda_oe_n(sda_oe_n),
		.i_sda     (o_sda),
		.o_scl     (scl),
		.o_sda_line(sda_line)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// one write transfer: device address, pointer, then data bytes
	task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
		logic ack;
		u_lps_host_model.start();
		u_lps_host_model.send(`LPS_BUS_ADDR_WR, ack);
		check("addr ack", ack, 1);
		u_lps_host_model.send(ptr, ack);
		check("ptr ack", ack, 1);
		foreach (d[i]) begin
			u_lps_host_model.send(d[i], ack);
			check("data ack", ack, 1);
		end
		u_lps_host_model.stop();
		u_lps_host_model.wt(12);
	endtask

	// on-time per channel over one full 256-clock pwm period
	task automatic expc(input int a, b, c, d, e);
		foreach (cnt[i]) cnt[i] = 0;
		repeat (256) begin
			@(negedge i_ref_clk);
			for (int i = 0; i < 18; i++) cnt[i] += outs[i] ? 1 : 0;
		end
		check("ch1 on", cnt[0], a);
		check("ch2 on", cnt[1], b);
		check("ch3 on", cnt[2], c);
		check("ch4 on", cnt[3], d);
		check("ch18 on", cnt[17], e);
	endtask

	// hang guard: the whole sequence needs well under this many clocks
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			test_done();
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (2) @(negedge i_ref_clk);
		i_rst = 1'b0;
		u_lps_host_model.wt(6);
		expc(0, 0, 0, 0, 0);
		wr(`LPS_OFF_SHUTDOWN, '{8'h01});
		// duty values give the on-steps directly, out of 256 per period
		wr(`LPS_OFF_DUTY, '{8'h04, 8'hFF, 8'h00, 8'h81});
		// pointer runs from last duty into the three enable registers
		wr(`LPS_OFF_DUTY_LAST, '{8'h10, 8'hC7, 8'h00, 8'h20});
		expc(0, 0, 0, 0, 0);
		wr(`LPS_OFF_COMMIT, '{8'h01});
		expc(0, 0, 0, 0, 0);
		wr(`LPS_OFF_COMMIT, '{`LPS_TRIGGER_KEY});
		expc(4, 255, 0, 0, 16);
		wr(`LPS_OFF_SHUTDOWN, '{8'h00});
		expc(0, 0, 0, 0, 0);
		wr(`LPS_OFF_SHUTDOWN, '{8'hFF});
		expc(4, 255, 0, 0, 16);
		pin_n = 1'b0;
		u_lps_host_model.wt(10);
		expc(0, 0, 0, 0, 0);
		pin_n = 1'b1;
		u_lps_host_model.wt(10);
		expc(4, 255, 0, 0, 16);
		wr(`LPS_OFF_RESET, '{8'h80});
		expc(4, 255, 0, 0, 16);
		wr(`LPS_OFF_RESET, '{`LPS_TRIGGER_KEY});
		expc(0, 0, 0, 0, 0);
		// shadows must be cleared too, so a commit brings nothing back
		wr(`LPS_OFF_SHUTDOWN, '{8'h01});
		wr(`LPS_OFF_COMMIT, '{`LPS_TRIGGER_KEY});
		expc(0, 0, 0, 0, 0);
		test_done();
	end
endmodule

// >>> logic/lps_consts.svh
// constants for the 18-channel led pwm block: register map, keys, sizes
// assumes a single 100 MHz system clock and a write-only two-wire bus
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LPS_OFF_SHUTDOWN   8'h00
`define LPS_OFF_DUTY       8'h01
`define LPS_OFF_DUTY_LAST  8'h12
`define LPS_OFF_ENABLE     8'h13
`define LPS_OFF_COMMIT     8'h16
`define LPS_OFF_RESET      8'h17
`define LPS_TRIGGER_KEY    8'h00
`define LPS_EN_PER_REG     6
`define LPS_EN_FIELD_W     6

// ----------------------------------------
// bus and sizes
// ----------------------------------------
`define LPS_BUS_ADDR_WR    8'hA8
`define LPS_CHANNELS       18
`define LPS_DUTY_W         8
`define LPS_BITS_PER_BYTE  4'h8
`define LPS_SYNC_IDLE      3'h7

// ----------------------------------------
// reset values
// ----------------------------------------
`define LPS_RST_DUTY       8'h00
`define LPS_RST_SSD        1'b0

`endif

// >>> logic/lps_pkg.sv
// types shared by the led pwm block
// assumes lps_consts.svh supplies all numeric values
package lps_pkg;

	// ----------------------------------------
	// bus receiver states and byte kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		LPS_ST_IDLE = 2'b00,
		LPS_ST_RX   = 2'b01,
		LPS_ST_ACK  = 2'b10,
		LPS_ST_SKIP = 2'b11
	} lps_state_t;

	typedef enum logic [1:0] {
		LPS_KIND_ADDR = 2'b00,
		LPS_KIND_REG  = 2'b01,
		LPS_KIND_DATA = 2'b10
	} lps_kind_t;

	// one register write as seen by the register file
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} lps_wr_t;

endpackage

// >>> logic/lps_top.sv
// two-wire write-only slave, shadowed duty/enable registers and pwm outputs
// assumes scl/sda pins are asynchronous and an external pull-up on sda
`timescale 1ns/1ps
`include "lps_consts.svh"

// What this block does
// - writes to duty/enable land in shadow only
// - zero written to commit copies shadows active
// - zero written to reset clears every register
// - power-up reset gives defaults, outputs dark
// - eighteen duty registers, value equals brightness step
// - shutdown keeps all register contents intact
// - shutdown bit zero forces all outputs off
// - low shutdown pin forces all outputs off
// - enable bit one on, zero off
// - shutdown bit one runs outputs normally
// - pointer advances by one per data byte
module lps_top #(
	parameter int CHANNELS = `LPS_CHANNELS
) (
	input  wire logic                i_ref_clk,
	input  wire logic                i_rst,
	input  wire logic                i_scl,
	input  wire logic                i_sda,
	output logic                     o_sda,
	output logic                     o_sda_oe_n,
	input  wire logic                i_shutdown_pin_n,
	output logic [CHANNELS-1:0]      o_channel_outputs
);

	// ----------------------------------------
	// pin synchronisers and glitch filter
	// ----------------------------------------
	logic [2:0]         scl_sync_reg;
	logic [2:0]         sda_sync_reg;
	logic [2:0]         sdn_sync_reg;
	logic               scl_f_reg;
	logic               sda_f_reg;
	logic               sdn_f_reg;
	logic               scl_q_reg;
	logic               sda_q_reg;

	// a level counts only once stages two and three agree
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			scl_sync_reg <= `LPS_SYNC_IDLE;
			sda_sync_reg <= `LPS_SYNC_IDLE;
			sdn_sync_reg <= `LPS_SYNC_IDLE;
			scl_f_reg    <= 1'b1;
			sda_f_reg    <= 1'b1;
			sdn_f_reg    <= 1'b1;
			scl_q_reg    <= 1'b1;
			sda_q_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
			sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
			sdn_sync_reg <= {sdn_sync_reg[1:0], i_shutdown_pin_n};
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_f_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_f_reg <= sda_sync_reg[2];
			if (sdn_sync_reg[1] == sdn_sync_reg[2])
				sdn_f_reg <= sdn_sync_reg[2];
			scl_q_reg <= scl_f_reg;
			sda_q_reg <= sda_f_reg;
		end
	end

	// bus events from the filtered levels
	wire scl_rise = scl_f_reg & ~scl_q_reg;
	wire scl_fall = ~scl_f_reg & scl_q_reg;
	wire bus_start = scl_f_reg & scl_q_reg & sda_q_reg & ~sda_f_reg;
	wire bus_stop = scl_f_reg & scl_q_reg & ~sda_q_reg & sda_f_reg;

	// ----------------------------------------
	// byte receiver
	// ----------------------------------------
	lps_pkg::lps_state_t state_reg;
	lps_pkg::lps_kind_t  kind_reg;
	logic [3:0]          bit_cnt_reg;
	logic [7:0]          shift_reg;
	logic [7:0]          ptr_reg;
	lps_pkg::lps_wr_t    wr;

	wire byte_done = scl_fall && state_reg == lps_pkg::LPS_ST_RX
		&& bit_cnt_reg == `LPS_BITS_PER_BYTE;
	wire addr_hit = shift_reg == `LPS_BUS_ADDR_WR;
	wire ack_end = scl_fall && state_reg == lps_pkg::LPS_ST_ACK;

	// a data byte is written while its ack is being driven
	assign wr = '{en: byte_done && kind_reg == lps_pkg::LPS_KIND_DATA,
		addr: ptr_reg, data: shift_reg};

	// read requests carry lsb one, so they miss the address and get no ack
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_reg   <= lps_pkg::LPS_ST_IDLE;
			kind_reg    <= lps_pkg::LPS_KIND_ADDR;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
			o_sda_oe_n  <= 1'b1;
		end else if (bus_start) begin
			state_reg   <= lps_pkg::LPS_ST_RX;
			kind_reg    <= lps_pkg::LPS_KIND_ADDR;
			bit_cnt_reg <= 4'h0;
			o_sda_oe_n  <= 1'b1;
		end else if (bus_stop) begin
			state_reg   <= lps_pkg::LPS_ST_IDLE;
			o_sda_oe_n  <= 1'b1;
		end else if (scl_rise && state_reg == lps_pkg::LPS_ST_RX) begin
			shift_reg   <= {shift_reg[6:0], sda_f_reg};
			bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end else if (byte_done) begin
			bit_cnt_reg <= 4'h0;
			if (kind_reg == lps_pkg::LPS_KIND_ADDR && !addr_hit) begin
				state_reg <= lps_pkg::LPS_ST_SKIP;
			end else begin
				state_reg  <= lps_pkg::LPS_ST_ACK;
				o_sda_oe_n <= 1'b0;
			end
			if (kind_reg == lps_pkg::LPS_KIND_REG)
				ptr_reg <= shift_reg;
		end else if (ack_end) begin
			state_reg  <= lps_pkg::LPS_ST_RX;
			o_sda_oe_n <= 1'b1;
			if (kind_reg == lps_pkg::LPS_KIND_ADDR) begin
				kind_reg <= lps_pkg::LPS_KIND_REG;
			end else begin
				kind_reg <= lps_pkg::LPS_KIND_DATA;
			end
			if (kind_reg == lps_pkg::LPS_KIND_DATA)
				ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// the pin is only ever pulled low; the enable decides
	assign o_sda = 1'b0;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	wire key_ok = wr.data == `LPS_TRIGGER_KEY;
	wire commit_w = wr.en && wr.addr == `LPS_OFF_COMMIT && key_ok;
	wire clear_w = wr.en && wr.addr == `LPS_OFF_RESET && key_ok;
	wire regs_rst = i_rst || clear_w;

	logic                                  ssd_reg;
	logic [7:0]                            pwm_cnt_reg;
	logic [CHANNELS-1:0][`LPS_DUTY_W-1:0] duty_shd;
	logic [CHANNELS-1:0][`LPS_DUTY_W-1:0] duty_act;
	logic [CHANNELS-1:0]                   en_shd;
	logic [CHANNELS-1:0]                   en_act;

	// both shutdowns only gate the outputs; no register is touched
	wire run = ssd_reg && sdn_f_reg;

	// shutdown bit is written directly, not through a shadow
	always_ff @(posedge i_ref_clk) begin
		if (regs_rst)
			ssd_reg <= `LPS_RST_SSD;
		else if (wr.en && wr.addr == `LPS_OFF_SHUTDOWN)
			ssd_reg <= wr.data[0];
	end

	// free-running step counter: duty n is high for n of 256 steps
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			pwm_cnt_reg <= 8'h00;
		else
			pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
	end

	// ----------------------------------------
	// per-channel shadow, active and output
	// ----------------------------------------
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		localparam logic [7:0] DUTY_OFF = 8'(`LPS_OFF_DUTY + i);
		localparam logic [7:0] EN_OFF =
			8'(`LPS_OFF_ENABLE + i / `LPS_EN_PER_REG);
		localparam int EN_BIT = i % `LPS_EN_PER_REG;
		wire duty_hit = wr.en && wr.addr == DUTY_OFF;
		wire en_hit = wr.en && wr.addr == EN_OFF;

		// shadows catch writes; actives move only on commit or reset
		always_ff @(posedge i_ref_clk) begin
			if (regs_rst) begin
				duty_shd[i] <= `LPS_RST_DUTY;
				duty_act[i] <= `LPS_RST_DUTY;
				en_shd[i]   <= 1'b0;
				en_act[i]   <= 1'b0;
			end else begin
				if (duty_hit)
					duty_shd[i] <= wr.data;
				if (en_hit)
					en_shd[i] <= wr.data[EN_BIT];
				if (commit_w) begin
					duty_act[i] <= duty_shd[i];
					en_act[i]   <= en_shd[i];
				end
			end
		end

		// output flop: gated by run and enable, compared to step
		always_ff @(posedge i_ref_clk) begin
			if (i_rst)
				o_channel_outputs[i] <= 1'b0;
			else
				o_channel_outputs[i] <= run && en_act[i]
					&& pwm_cnt_reg < duty_act[i];
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	// a data byte taken, then the fall that ends a data ack
	sequence data_ack_s;
		byte_done && kind_reg == lps_pkg::LPS_KIND_DATA
			##[1:200] (ack_end && kind_reg == lps_pkg::LPS_KIND_DATA);
	endsequence

	sequence pin_low_s;
		!sdn_f_reg [*2];
	endsequence

	shadow_only_a: assert property (
		wr.en && !commit_w && !clear_w |=> $stable(duty_act)
			&& $stable(en_act))
		else $error("active registers moved without a commit");
	commit_copy_a: assert property (
		commit_w |=> duty_act == $past(duty_shd)
			&& en_act == $past(en_shd))
		else $error("commit did not copy the shadows");
	reg_clear_a: assert property (
		clear_w |=> duty_act == '0 && duty_shd == '0 && en_shd == '0
			&& en_act == '0 && !ssd_reg)
		else $error("reset register write left state");
	power_up_a: assert property (disable iff (1'b0)
		i_rst ##1 i_rst |=> o_channel_outputs == '0 && !ssd_reg)
		else $error("outputs not dark after power-up reset");
	duty_step_a: assert property (
		run && en_act[0] |=> o_channel_outputs[0]
			== ($past(pwm_cnt_reg) < $past(duty_act[0])))
		else $error("channel 0 does not follow its duty");
	keep_regs_a: assert property (
		!run && !wr.en |=> $stable(duty_shd) && $stable(duty_act)
			&& $stable(en_act) && $stable(ssd_reg))
		else $error("registers changed during shutdown");
	soft_off_a: assert property (
		!ssd_reg |=> o_channel_outputs == '0)
		else $error("output on in software shutdown");
	hard_off_a: assert property (
		pin_low_s |=> o_channel_outputs == '0)
		else $error("output on with shutdown pin low");
	en_gate_a: assert property (
		!en_act[0] |=> !o_channel_outputs[0])
		else $error("disabled channel 0 is driven");
	full_on_a: assert property (
		run && en_act[0] && duty_act[0] == 8'hFF && pwm_cnt_reg != 8'hFF
			|=> o_channel_outputs[0])
		else $error("normal mode did not drive channel 0");
	ptr_step_a: assert property (
		data_ack_s |=> ptr_reg == $past(ptr_reg) + 8'h01)
		else $error("pointer did not advance after a data byte");
	bad_key_a: assert property (
		wr.en && !key_ok && (wr.addr == `LPS_OFF_COMMIT
			|| wr.addr == `LPS_OFF_RESET) |=> $stable(duty_act)
			&& $stable(en_act) && $stable(ssd_reg))
		else $error("nonzero trigger write had an effect");

endmodule
